// ### src/dma_crc_reorder_unit.sv
`timescale 1ns/1ps
module dma_crc_reorder_unit
    import crc_reorder_pkg::*;
#(
    parameter int CHANNELS = 8
)(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        src_valid_i,
    output logic             src_ready_o,
    input  wire beat_s       src_beat_i,
    input  wire logic        src_aligned_i,
    input  wire logic        src_last_i,
    output logic             dst_valid_o,
    input  wire logic        dst_ready_i,
    output beat_s            dst_beat_o,
    output logic             unaligned_error_o
);

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    logic [31:0] control;
    logic [31:0] crc_value;
    logic [31:0] poly;
    logic [15:0] src_size [CHANNELS];
    logic [15:0] dst_size [CHANNELS];
    logic        append_pending;

    wire logic       bus_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire logic       bus_write = bus_req && wb_we_i;
    wire logic [1:0] byte_order = control[POS_BYTE_ORDER +: 2];
    wire logic       write_reorder = control[POS_WRITE_REORDER];
    wire logic       bit_order  = control[POS_BIT_ORDER];
    wire logic [4:0] poly_len_m1 = control[POS_POLY_LEN +: 5];
    wire logic       crc_enable = control[POS_ENABLE];
    wire logic       append_mode = control[POS_APPEND];
    wire logic       checksum_type = control[POS_TYPE];
    wire logic [2:0] crc_channel = control[POS_CHANNEL +: 3];

    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++)
        begin
            if (sel[b])
                r[8*b +: 8] = new_v[8*b +: 8];
        end
        return r;
    endfunction : lane_merge

    function automatic logic [31:0] reorder(input logic [31:0] w,
                                            input logic [1:0]  code);
        logic [31:0] r;
        r = w;
        unique case (code)
            ORDER_NONE:      r = w;
            ORDER_WORD_REV:  r = {w[7:0], w[15:8], w[23:16], w[31:24]};
            ORDER_HALF_SWAP: r = {w[15:0], w[31:16]};
            ORDER_BYTE_SWAP: r = {w[23:16], w[31:24], w[7:0], w[15:8]};
        endcase
        return r;
    endfunction : reorder

    function automatic logic [31:0] bit_rev(input logic [31:0] w);
        logic [31:0] r;
        r = '0;
        for (int i = 0; i < 32; i++)
            r[i] = w[31-i];
        return r;
    endfunction : bit_rev

    // Control write: append may not be set while reordered writes are on
    wire logic [31:0] control_merged =
        lane_merge(control, wb_dat_i, wb_sel_i) & CONTROL_MASK;
    wire logic [31:0] next_control = control_merged[POS_WRITE_REORDER]
        ? (control_merged & ~(32'h0000_0001 << POS_APPEND))
        : control_merged;

    wire logic       hit_control = wb_adr_i == ADDR_CRC_CONTROL;
    wire logic       hit_data    = wb_adr_i == ADDR_CRC_DATA;
    wire logic [7:0] size_off    = wb_adr_i - ADDR_SIZE_BASE;
    wire logic       hit_size    = (wb_adr_i >= ADDR_SIZE_BASE) &&
        (size_off < 8'(CHANNELS * SIZE_STRIDE)) && (wb_adr_i[1:0] == 2'h0);
    wire logic [2:0] size_chan   = size_off[5:3];
    wire logic       size_is_dst = size_off[2];

    logic [31:0] read_mux;
    always_comb
    begin
        read_mux = 32'h0000_0000;
        if (hit_control)
            read_mux = control;
        else if (hit_data)
            read_mux = crc_value;
        else if (hit_size)
            read_mux = {16'h0000, size_is_dst ? dst_size[size_chan]
                                              : src_size[size_chan]};
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            control  <= CONTROL_RESET;
        end
        else
        begin
            wb_ack_o <= bus_req;
            wb_dat_o <= read_mux;
            if (bus_write && hit_control)
                control <= next_control;
        end
    end

    // ------------------------------------------------------------------
    // Per channel size registers
    // ------------------------------------------------------------------
    for (genvar c = 0; c < CHANNELS; c++)
    begin : g_size
        wire logic wr_c = bus_write && hit_size && (size_chan == 3'(c));
        always_ff @(posedge clk_i)
        begin
            if (rst_i)
            begin
                src_size[c] <= SIZE_RESET;
                dst_size[c] <= SIZE_RESET;
            end
            else if (wr_c && !size_is_dst)
                src_size[c] <= 16'(lane_merge({16'h0000, src_size[c]},
                                              wb_dat_i, wb_sel_i));
            else if (wr_c && size_is_dst)
                dst_size[c] <= 16'(lane_merge({16'h0000, dst_size[c]},
                                              wb_dat_i, wb_sel_i));
        end
    end

    // ------------------------------------------------------------------
    // Engine
    // ------------------------------------------------------------------
    wire logic   observed = crc_enable &&
                            (src_beat_i.channel == crc_channel);
    wire logic [31:0] ordered = reorder(src_beat_i.data, byte_order);
    wire logic [31:0] calc_in = bit_order ? bit_rev(ordered) : ordered;
    wire logic   bad_beat = observed && write_reorder && !src_aligned_i;

    // LFSR over 32 input bits; width is poly_len_m1 + 1
    wire logic [5:0]  poly_width = {1'b0, poly_len_m1} + 6'h01;
    wire logic [31:0] width_mask = (poly_width == 6'd32) ? 32'hFFFF_FFFF
                                  : ((32'h0000_0001 << poly_width) - 1);
    logic [31:0] lfsr_next;
    always_comb
    begin
        logic fb;
        lfsr_next = crc_value;
        fb = 1'b0;
        for (int i = 31; i >= 0; i--)
        begin
            fb = lfsr_next[poly_len_m1] ^ calc_in[i];
            lfsr_next = ((lfsr_next << 1) ^ (fb ? poly : 32'h0000_0000))
                        & width_mask;
        end
    end

    // Ones complement sum of half-words; reflection sums reversed words
    wire logic [16:0] s1 = {1'b0, crc_value[15:0]} + {1'b0, calc_in[15:0]};
    wire logic [15:0] f1 = s1[15:0] + {15'h0000, s1[16]};
    wire logic [16:0] s2 = {1'b0, f1} + {1'b0, calc_in[31:16]};
    wire logic [15:0] f2 = s2[15:0] + {15'h0000, s2[16]};
    wire logic [31:0] ip_next = {16'h0000, f2};

    wire logic [31:0] next_crc = checksum_type ? ip_next : lfsr_next;

    // ------------------------------------------------------------------
    // Two-entry output buffer
    // ------------------------------------------------------------------
    beat_s       buf_q [2];
    logic [1:0]  count;
    logic        wr_ptr;
    logic        rd_ptr;
    wire logic   buf_full = count == 2'd2;
    wire logic   push_ok  = !buf_full;
    // Append holds the source port while the result beat is emitted
    assign src_ready_o = push_ok && !append_pending;

    wire logic   src_take = src_valid_i && src_ready_o;
    wire logic   drop_src = observed && append_mode;
    wire logic   push_src = src_take && !drop_src && !bad_beat;
    wire logic   push_res = append_pending && push_ok;
    beat_s       push_beat;
    always_comb
    begin
        push_beat.channel = src_beat_i.channel;
        push_beat.data    = (observed && write_reorder) ? ordered
                                                        : src_beat_i.data;
        if (push_res)
        begin
            push_beat.channel = crc_channel;
            push_beat.data    = crc_value;
        end
    end
    wire logic   push = push_src || push_res;
    wire logic   pop  = dst_valid_o && dst_ready_i;
    assign dst_valid_o = count != 2'd0;
    assign dst_beat_o  = buf_q[rd_ptr];

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            count  <= 2'd0;
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            buf_q[0] <= '0;
            buf_q[1] <= '0;
        end
        else
        begin
            if (push)
            begin
                buf_q[wr_ptr] <= push_beat;
                wr_ptr <= !wr_ptr;
            end
            if (pop)
                rd_ptr <= !rd_ptr;
            count <= count + 2'(push) - 2'(pop);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            crc_value         <= CRC_SEED_RESET;
            poly              <= CRC_POLY_RESET;
            append_pending    <= 1'b0;
            unaligned_error_o <= 1'b0;
        end
        else
        begin
            if (bus_write && hit_data)
                crc_value <= lane_merge(crc_value, wb_dat_i, wb_sel_i);
            else if (src_take && observed && !bad_beat)
                crc_value <= next_crc;
            if (push_res)
                append_pending <= 1'b0;
            else if (src_take && drop_src && src_last_i)
                append_pending <= 1'b1;
            unaligned_error_o <= src_take && bad_beat;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    append_blocked_a: assert property (write_reorder |-> !append_mode)
        else $error("append set while write reorder on");
    reserved_zero_a: assert property ((control & ~CONTROL_MASK) == 0)
        else $error("reserved control bits nonzero");
    bypass_data_a: assert property (src_take && !observed && !buf_full
        |=> buf_q[$past(wr_ptr)].data == $past(src_beat_i.data))
        else $error("bypass beat altered");
    append_drop_a: assert property (src_take && drop_src |-> !push_src)
        else $error("source beat passed in append mode");
    half_swap_a: assert property (byte_order == ORDER_HALF_SWAP
        |-> ordered == {src_beat_i.data[15:0], src_beat_i.data[31:16]})
        else $error("half word swap wrong");
    reorder_out_a: assert property (push_src && observed && write_reorder
        |=> buf_q[$past(wr_ptr)].data == $past(ordered))
        else $error("reordered write wrong");
    size_upper_a: assert property (wb_ack_o && $past(hit_size)
        |-> wb_dat_o[31:16] == 16'h0000)
        else $error("size upper bits nonzero");
    ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");
    crc_width_a: assert property (src_take && observed && !checksum_type
        && !bad_beat |=> (crc_value & ~$past(width_mask)) == 0)
        else $error("crc wider than polynomial");

    // ------------------------------------------------------------------
    // Multi-step checks
    // ------------------------------------------------------------------
    sequence last_dropped_s;
        src_take && drop_src && src_last_i;
    endsequence

    sequence result_held_s;
        append_pending && !src_ready_o;
    endsequence

    sequence unaligned_take_s;
        src_take && bad_beat;
    endsequence

    sequence ack_pulse_s;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    append_result_a: assert property (
        last_dropped_s |=> result_held_s)
        else $error("append result not pending");
    unaligned_drop_a: assert property (
        unaligned_take_s |-> !push_src ##1 unaligned_error_o)
        else $error("unaligned beat not dropped and flagged");
    bypass_crc_a: assert property (
        src_take && !crc_enable && !(bus_write && hit_data)
        |=> $stable(crc_value))
        else $error("disabled engine changed the result");
    ip_upper_a: assert property (
        src_take && observed && checksum_type && !bad_beat
        && !(bus_write && hit_data) |=> crc_value[31:16] == 16'h0000)
        else $error("checksum wider than a half-word");
    ack_answer_a: assert property (bus_req |=> ack_pulse_s)
        else $error("bus request not answered in one cycle");
    dst_hold_a: assert property (dst_valid_o && !dst_ready_i
        |=> dst_valid_o && $stable(dst_beat_o))
        else $error("stalled output beat changed");

endmodule : dma_crc_reorder_unit

// ### src/crc_reorder_pkg.sv
package crc_reorder_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses, chosen)
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CRC_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_CRC_DATA    = 8'h04;
    localparam logic [7:0] ADDR_SIZE_BASE   = 8'h40;
    localparam int         SIZE_STRIDE      = 8;

    // ------------------------------------------------------------------
    // Control field positions
    // ------------------------------------------------------------------
    localparam int POS_BYTE_ORDER = 28;
    localparam int POS_WRITE_REORDER = 27;
    localparam int POS_BIT_ORDER  = 24;
    localparam int POS_POLY_LEN   = 8;
    localparam int POS_ENABLE     = 7;
    localparam int POS_APPEND     = 6;
    localparam int POS_TYPE       = 5;
    localparam int POS_CHANNEL    = 0;

    localparam logic [31:0] CONTROL_RESET   = 32'h0000_0000;
    localparam logic [31:0] CONTROL_MASK    = 32'h3900_1FE7;
    localparam logic [15:0] SIZE_RESET      = 16'h0000;
    localparam logic [31:0] CRC_SEED_RESET  = 32'h0000_0000;
    localparam logic [31:0] CRC_POLY_RESET  = 32'h04C1_1DB7;

    // ------------------------------------------------------------------
    // Byte order codes
    // ------------------------------------------------------------------
    localparam logic [1:0] ORDER_NONE      = 2'h0;
    localparam logic [1:0] ORDER_WORD_REV  = 2'h1;
    localparam logic [1:0] ORDER_HALF_SWAP = 2'h2;
    localparam logic [1:0] ORDER_BYTE_SWAP = 2'h3;

    typedef struct packed {
        logic [31:0] data;
        logic [2:0]  channel;
    } beat_s;

endpackage : crc_reorder_pkg

// ### tb/dma_channel_model.sv
`timescale 1ns/1ps
module dma_channel_model
    import crc_reorder_pkg::*;
(
    input  wire logic  clk_i,
    input  wire logic  src_ready_i,
    input  wire logic  dst_valid_i,
    input  wire beat_s dst_beat_i,
    input  wire logic  stall_i,
    output logic       src_valid_o = 1'b0,
    output beat_s      src_beat_o = '0,
    output logic       src_aligned_o = 1'b0,
    output logic       src_last_o = 1'b0,
    output logic       dst_ready_o
);
    // ----------------------------------------
    // Channel source and a stalling sink
    // ----------------------------------------
    beat_s rx_q [$];
    assign dst_ready_o = !stall_i;
    always @(posedge clk_i)
        if (dst_valid_i && dst_ready_o)
            rx_q.push_back(dst_beat_i);
    task automatic send(input beat_s b, input logic al, input logic l);
        int n;
        n = 0;
        src_valid_o   <= 1'b1;
        src_beat_o    <= b;
        src_aligned_o <= al;
        src_last_o    <= l;
        do @(posedge clk_i); while (!src_ready_i && ++n < 50);
        if (n >= 50) tb.close_out(1);
        // Released lines carry junk so a stale word never looks valid
        src_valid_o   <= 1'b0;
        src_beat_o    <= ~b;
        src_aligned_o <= ~al;
        src_last_o    <= ~l;
    endtask : send
endmodule : dma_channel_model

// ### tb/tb.sv
`timescale 1ns/1ps
module tb;
    import crc_reorder_pkg::*;
    typedef struct {logic [31:0] ctl, wd, ex; logic [7:0] adr;} row_s;
    logic        clk = 1'b0, rst = 1'b1, stall = 1'b0;
    logic        wb_req = 1'b0, wb_we = 1'b0, ack, src_valid, src_ready;
    logic        aligned, last, dst_valid, dst_ready, err_pulse;
    logic [7:0]  wb_adr = 8'h00;
    logic [3:0]  wb_sel = 4'hF;
    logic [31:0] wb_wd = 32'h0, wb_rd, rd;
    beat_s       src_beat, dst_beat, got;
    int          err_total = 0, check_count = 0, err_seen = 0;
    dma_crc_reorder_unit #(.CHANNELS(8)) dut (.clk_i(clk), .rst_i(rst),
        .wb_cyc_i(wb_req), .wb_stb_i(wb_req), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wd),
        .wb_dat_o(wb_rd), .wb_ack_o(ack), .src_valid_i(src_valid),
        .src_ready_o(src_ready), .src_beat_i(src_beat),
        .src_aligned_i(aligned), .src_last_i(last), .dst_valid_o(dst_valid),
        .dst_ready_i(dst_ready), .dst_beat_o(dst_beat),
        .unaligned_error_o(err_pulse));
    dma_channel_model m (.clk_i(clk), .src_ready_i(src_ready),
        .dst_valid_i(dst_valid), .dst_beat_i(dst_beat), .stall_i(stall),
        .src_valid_o(src_valid), .src_beat_o(src_beat),
        .src_aligned_o(aligned), .src_last_o(last), .dst_ready_o(dst_ready));
    initial forever #2.5 clk = ~clk;
    always @(posedge clk) err_seen += (err_pulse === 1'b1);
    // ----------------------------------------
    // Rows: control, then register or beat
    // ----------------------------------------
    // Address FF sends 1122_3344 on channel 2
    row_s rows [12] = '{
        '{32'h0, 32'hFFFF_FFFF, 32'h3900_1FA7, 8'h00},
        '{32'h0, 32'h00FF_E000, 32'h0, 8'h00},
        '{32'h0, 32'hFFFF_FFFF, 32'h0000_FFFF, 8'h40},
        '{32'h0, 32'h1234_ABCD, 32'h0000_ABCD, 8'h7C},
        '{32'h0, 32'hFFFF_FFFF, 32'h0, 8'h20},
        '{32'h3800_0082, 32'h0, 32'h2211_4433, 8'hFF},
        '{32'h2800_0082, 32'h0, 32'h3344_1122, 8'hFF},
        '{32'h1800_0082, 32'h0, 32'h4433_2211, 8'hFF},
        '{32'h0800_0082, 32'h0, 32'h1122_3344, 8'hFF},
        '{32'h1000_0082, 32'h0, 32'h1122_3344, 8'hFF},
        '{32'h1800_0002, 32'h0, 32'h1122_3344, 8'hFF},
        '{32'h1800_0083, 32'h0, 32'h1122_3344, 8'hFF}
    };
    task chk32(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk32
    task close_out(input int bump);
        err_total += bump;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : close_out
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        wb_req <= 1'b1;
        wb_we  <= w;
        wb_adr <= a;
        wb_wd  <= d;
        do @(posedge clk); while (ack !== 1'b1 && ++n < 20);
        if (n >= 20) close_out(1);
        rd = wb_rd;
        wb_req <= 1'b0;
    endtask : wb
    task put(input logic [31:0] d, input logic al, input logic l);
        @(posedge clk);
        m.send({d, 3'h2}, al, l);
    endtask : put
    task rx();
        int n;
        n = 0;
        while (m.rx_q.size() == 0 && n++ < 50) @(posedge clk);
        if (m.rx_q.size() == 0) close_out(1);
        got = m.rx_q.pop_front();
    endtask : rx
    // Seed cleared first so each block starts its own sum
    task ipsum(input logic [31:0] c, input logic [31:0] e);
        wb(1'b1, ADDR_CRC_CONTROL, c);
        wb(1'b1, ADDR_CRC_DATA, 32'h0);
        put(32'h0001_0002, 1'b1, 1'b0);
        put(32'h0003_0004, 1'b1, 1'b1);
        rx();
        chk32(got.data, e);
        chk32({29'h0, got.channel}, 32'h2);
        repeat (3) @(posedge clk);
        chk32(32'(m.rx_q.size()), 32'h0);
    endtask : ipsum
    initial
    begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        foreach (rows[i])
        begin
            wb(1'b1, ADDR_CRC_CONTROL, rows[i].ctl);
            if (rows[i].adr != 8'hFF)
            begin
                wb(1'b1, rows[i].adr, rows[i].wd);
                wb(1'b0, rows[i].adr, 32'h0);
                chk32(rd, rows[i].ex);
            end
            else
            begin
                put(32'h1122_3344, 1'b1, 1'b0);
                rx();
                chk32(got.data, rows[i].ex);
            end
        end
        wb(1'b1, ADDR_CRC_CONTROL, 32'h1800_0082);
        put(32'h1122_3344, 1'b0, 1'b0);
        repeat (4) @(posedge clk);
        chk32(32'(err_seen), 32'h1);
        chk32(32'(m.rx_q.size()), 32'h0);
        ipsum(32'h0000_1FE2, 32'h0000_000A);
        ipsum(32'h0100_00E2, 32'h0000_A001);
        ipsum(32'h0000_01C2, 32'h0000_0001);
        wb(1'b1, ADDR_CRC_CONTROL, 32'h0);
        stall <= 1'b1;
        put(32'h0000_00A1, 1'b1, 1'b0);
        put(32'h0000_00B2, 1'b1, 1'b0);
        @(posedge clk);
        chk32({31'h0, src_ready}, 32'h0);
        stall <= 1'b0;
        rx();
        chk32(got.data, 32'h0000_00A1);
        rx();
        chk32(got.data, 32'h0000_00B2);
        rst <= 1'b1;
        repeat (5) @(posedge clk);
        chk32({31'h0, src_ready}, 32'h1);
        rst <= 1'b0;
        wb(1'b0, 8'h7C, 32'h0);
        chk32(rd, 32'h0);
        wb_sel <= 4'h2;
        wb(1'b1, 8'h44, 32'hFFFF_FFFF);
        wb_sel <= 4'hF;
        wb(1'b0, 8'h44, 32'h0);
        chk32(rd, 32'h0000_FF00);
        close_out(0);
    end
endmodule : tb
